// ==== verilog/gpio_pkg.sv ====
package gpio_pkg;

  // ==========================================================================
  // File addresses of the five groups.
  localparam logic [4:0] ADDR_GROUP_A = 5'h05;
  localparam logic [4:0] ADDR_GROUP_B = 5'h06;
  localparam logic [4:0] ADDR_GROUP_C = 5'h07;
  localparam logic [4:0] ADDR_GROUP_D = 5'h08;
  localparam logic [4:0] ADDR_GROUP_E = 5'h09;

  // ==========================================================================
  // Group indexes and implemented-pin layouts.
  localparam logic [2:0] IDX_GROUP_A = 3'h0;
  localparam logic [2:0] IDX_GROUP_B = 3'h1;
  localparam logic [2:0] IDX_GROUP_C = 3'h2;
  localparam logic [2:0] IDX_GROUP_D = 3'h3;
  localparam logic [2:0] IDX_GROUP_E = 3'h4;
  localparam logic [2:0] IDX_NONE    = 3'h7;
  localparam int         NUM_GROUPS  = 5;

  localparam logic [7:0] MASK_GROUP_A = 8'h0f;
  localparam logic [7:0] MASK_GROUP_B = 8'hff;
  localparam logic [7:0] MASK_GROUP_C = 8'hff;
  localparam logic [7:0] MASK_GROUP_D = 8'hff;
  localparam logic [7:0] MASK_GROUP_E = 8'hf0;
  localparam logic [7:0] MASK_STORAGE = 8'hff;

  // ==========================================================================
  // Reset values and read answers.
  localparam logic [7:0] DIRECTION_RESET = 8'hff;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // ==========================================================================
  // Device variants, smallest to largest.
  localparam logic [1:0] VARIANT_SMALL = 2'h0;
  localparam logic [1:0] VARIANT_MID   = 2'h1;
  localparam logic [1:0] VARIANT_LARGE = 2'h2;

endpackage

// ==== verilog/pin_sync.sv ====
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // ==========================================================================
  // Two stages; only the second stage is read outside this module.
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

// ==== verilog/io_group_slice.sv ====
module io_group_slice #(
  parameter bit         IS_PORT = 1'b1,
  parameter logic [7:0] MASK    = 8'hff
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_pins_sync,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_dir_wr,
  input  wire logic [7:0] i_dir_data,
  output logic      [7:0] o_rd_value,
  output logic      [7:0] o_pins,
  output logic      [7:0] o_pins_oe
);

  // ==========================================================================
  // Output latch, or plain storage when the group is not a port.
  logic [7:0] next_latch;
  logic [7:0] next_drive_en;

  always_comb begin
    next_latch    = o_pins;
    next_drive_en = o_pins_oe;
    if (i_wr) begin
      next_latch = IS_PORT ? (i_wr_data & MASK) : i_wr_data;
    end
    if (i_dir_wr && IS_PORT) begin
      next_drive_en = ~i_dir_data & MASK;
    end
  end

  // The latch keeps its contents across reset, so it has no reset branch.
  always_ff @(posedge i_clk) begin
    o_pins <= next_latch;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pins_oe <= ~gpio_pkg::DIRECTION_RESET;
    end else begin
      o_pins_oe <= next_drive_en;
    end
  end

  // ==========================================================================
  // A port reads its pins; storage reads itself.
  always_comb begin
    o_rd_value = IS_PORT ? (i_pins_sync & MASK) : o_pins;
  end

endmodule

// ==== verilog/io_ports.sv ====
// Summary of operation
// - Port reads return pin levels, not latches.
// - Reset sets every direction bit to one.
// - Group A has pins 3..0; 7..4 read zero.
// - Group B is a full eight-bit port.
// - Group C is port on larger variants, else storage.
// - Group D is port only on largest variant.
// - Group E pins 7..4 on largest, else storage.
// - Direction load copies W into named direction.
// - Direction one tristates; zero drives latch bit.
// - Direction registers cannot be read back.
// - Latches hold until software writes again.
// - Every pin has its own direction bit.
// - Bit set/clear rewrites the addressed latch from pins.
// - Writes land at cycle end; reads sample start.
module io_ports #(
  parameter logic [1:0] VARIANT = gpio_pkg::VARIANT_LARGE
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [4:0] i_file_addr,
  input  wire logic       i_rd_en,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_bit_set,
  input  wire logic       i_bit_clr,
  input  wire logic [2:0] i_bit_pos,
  input  wire logic       i_dir_load,
  input  wire logic [7:0] i_w_reg,
  input  wire logic [7:0] i_pins_a,
  input  wire logic [7:0] i_pins_b,
  input  wire logic [7:0] i_pins_c,
  input  wire logic [7:0] i_pins_d,
  input  wire logic [7:0] i_pins_e,
  output logic      [7:0] o_rd_data,
  output logic            o_rd_valid,
  output logic      [7:0] o_pins_a,
  output logic      [7:0] o_pins_b,
  output logic      [7:0] o_pins_c,
  output logic      [7:0] o_pins_d,
  output logic      [7:0] o_pins_e,
  output logic      [7:0] o_pins_a_oe,
  output logic      [7:0] o_pins_b_oe,
  output logic      [7:0] o_pins_c_oe,
  output logic      [7:0] o_pins_d_oe,
  output logic      [7:0] o_pins_e_oe
);

  // ==========================================================================
  // Decoding helpers.
  function automatic logic [2:0] group_index(input logic [4:0] addr);
    logic [2:0] idx;
    idx = gpio_pkg::IDX_NONE;
    case (addr)
      gpio_pkg::ADDR_GROUP_A: idx = gpio_pkg::IDX_GROUP_A;
      gpio_pkg::ADDR_GROUP_B: idx = gpio_pkg::IDX_GROUP_B;
      gpio_pkg::ADDR_GROUP_C: idx = gpio_pkg::IDX_GROUP_C;
      gpio_pkg::ADDR_GROUP_D: idx = gpio_pkg::IDX_GROUP_D;
      gpio_pkg::ADDR_GROUP_E: idx = gpio_pkg::IDX_GROUP_E;
      default:                idx = gpio_pkg::IDX_NONE;
    endcase
    return idx;
  endfunction

  function automatic bit group_is_port(input int idx, input logic [1:0] variant);
    bit port;
    port = 1'b0;
    case (idx)
      0:       port = 1'b1;
      1:       port = 1'b1;
      2:       port = (variant != gpio_pkg::VARIANT_SMALL);
      3:       port = (variant == gpio_pkg::VARIANT_LARGE);
      4:       port = (variant == gpio_pkg::VARIANT_LARGE);
      default: port = 1'b0;
    endcase
    return port;
  endfunction

  function automatic logic [7:0] group_mask(input int idx, input logic [1:0] variant);
    logic [7:0] mask;
    mask = gpio_pkg::MASK_STORAGE;
    if (group_is_port(idx, variant)) begin
      case (idx)
        0:       mask = gpio_pkg::MASK_GROUP_A;
        1:       mask = gpio_pkg::MASK_GROUP_B;
        2:       mask = gpio_pkg::MASK_GROUP_C;
        3:       mask = gpio_pkg::MASK_GROUP_D;
        4:       mask = gpio_pkg::MASK_GROUP_E;
        default: mask = gpio_pkg::MASK_STORAGE;
      endcase
    end
    return mask;
  endfunction

  // ==========================================================================
  // Pin arrays.
  logic [7:0] pins_raw  [gpio_pkg::NUM_GROUPS];
  logic [7:0] pins_sync [gpio_pkg::NUM_GROUPS];
  logic [7:0] rd_value  [gpio_pkg::NUM_GROUPS];
  logic [7:0] latch_out [gpio_pkg::NUM_GROUPS];
  logic [7:0] drive_out [gpio_pkg::NUM_GROUPS];
  logic       grp_wr    [gpio_pkg::NUM_GROUPS];
  logic       grp_dir   [gpio_pkg::NUM_GROUPS];

  assign pins_raw[0] = i_pins_a;
  assign pins_raw[1] = i_pins_b;
  assign pins_raw[2] = i_pins_c;
  assign pins_raw[3] = i_pins_d;
  assign pins_raw[4] = i_pins_e;

  assign o_pins_a    = latch_out[0];
  assign o_pins_b    = latch_out[1];
  assign o_pins_c    = latch_out[2];
  assign o_pins_d    = latch_out[3];
  assign o_pins_e    = latch_out[4];
  assign o_pins_a_oe = drive_out[0];
  assign o_pins_b_oe = drive_out[1];
  assign o_pins_c_oe = drive_out[2];
  assign o_pins_d_oe = drive_out[3];
  assign o_pins_e_oe = drive_out[4];

  // ==========================================================================
  // Operation decode. Only one write-type operation acts per cycle; direction load
  // wins over bit operations, which win over a plain write.
  logic [2:0] op_idx;
  logic       op_hit;
  logic       do_dir;
  logic       do_bit;
  logic       do_wr;
  logic [7:0] bit_mask;
  logic [7:0] rmw_source;
  logic [7:0] write_value;

  always_comb begin
    op_idx     = group_index(i_file_addr);
    op_hit     = (op_idx != gpio_pkg::IDX_NONE);
    do_dir     = op_hit && i_dir_load;
    do_bit     = op_hit && !i_dir_load && (i_bit_set || i_bit_clr);
    do_wr      = op_hit && !i_dir_load && !i_bit_set && !i_bit_clr && i_wr_en;
    bit_mask   = 8'h01 << i_bit_pos;
    rmw_source = op_hit ? rd_value[op_idx] : gpio_pkg::READ_UNMAPPED;
    if (do_bit) begin
      if (i_bit_set) begin
        write_value = rmw_source | bit_mask;
      end else begin
        write_value = rmw_source & ~bit_mask;
      end
    end else begin
      write_value = i_wr_data;
    end
  end

  // ==========================================================================
  // Per-group synchronisers and latches.
  generate
    for (genvar g = 0; g < gpio_pkg::NUM_GROUPS; g++) begin : grp
      assign grp_wr[g]  = (do_wr || do_bit) && (op_idx == 3'(g));
      assign grp_dir[g] = do_dir && (op_idx == 3'(g));

      pin_sync #(
        .WIDTH(8)
      ) u_sync (
        .i_clk    (i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async  (pins_raw[g]),
        .o_sync   (pins_sync[g])
      );

      io_group_slice #(
        .IS_PORT(group_is_port(g, VARIANT)),
        .MASK   (group_mask(g, VARIANT))
      ) u_slice (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_pins_sync(pins_sync[g]),
        .i_wr       (grp_wr[g]),
        .i_wr_data  (write_value),
        .i_dir_wr   (grp_dir[g]),
        .i_dir_data (i_w_reg),
        .o_rd_value (rd_value[g]),
        .o_pins     (latch_out[g]),
        .o_pins_oe  (drive_out[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Read path. A port returns the synchronised pin level present at the
  // start of the cycle, so a read right after a write may still see the
  // old pin level; software must leave two spare cycles between them.
  logic [7:0] next_rd_data;
  logic       next_rd_valid;
  logic [2:0] rd_idx;
  logic [2:0] next_rd_idx;

  always_comb begin
    next_rd_data  = gpio_pkg::READ_UNMAPPED;
    next_rd_valid = 1'b0;
    next_rd_idx   = gpio_pkg::IDX_NONE;
    if (i_rd_en && op_hit) begin
      next_rd_data  = rd_value[op_idx];
      next_rd_valid = 1'b1;
      next_rd_idx   = op_idx;
    end
  end

  // Direction state never enters this mux, so it cannot be read back.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data  <= gpio_pkg::READ_UNMAPPED;
      o_rd_valid <= 1'b0;
      rd_idx     <= gpio_pkg::IDX_NONE;
    end else begin
      o_rd_data  <= next_rd_data;
      o_rd_valid <= next_rd_valid;
      rd_idx     <= next_rd_idx;
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  logic b_write_any;
  assign b_write_any = grp_wr[1] || grp_dir[1];

  AST_DIR_RESET: assert property (
    $past(i_sys_rst) |-> (o_pins_a_oe == 8'h00) && (o_pins_b_oe == 8'h00) && (o_pins_e_oe == 8'h00))
    else $error("Direction not all input after reset.");

  AST_READ_PINS: assert property (
    (i_rd_en && i_file_addr == gpio_pkg::ADDR_GROUP_B) |=> o_rd_valid && (o_rd_data == $past(pins_sync[1])))
    else $error("Group B read did not return pin level.");

  AST_A_UPPER_ZERO: assert property (
    (o_rd_valid && rd_idx == gpio_pkg::IDX_GROUP_A) |-> (o_rd_data[7:4] == 4'h0))
    else $error("Group A upper bits not zero.");

  AST_E_LOWER_ZERO: assert property (
    (o_rd_valid && rd_idx == gpio_pkg::IDX_GROUP_E && VARIANT == gpio_pkg::VARIANT_LARGE)
      |-> (o_rd_data[3:0] == 4'h0))
    else $error("Group E lower bits not zero.");

  AST_DIR_LOAD: assert property (
    (i_dir_load && i_file_addr == gpio_pkg::ADDR_GROUP_B) |=> (o_pins_b_oe == ~$past(i_w_reg)))
    else $error("Direction load did not follow W.");

  AST_WRITE_LATCH: assert property (
    (do_wr && op_idx == gpio_pkg::IDX_GROUP_B) |=> (o_pins_b == $past(i_wr_data)))
    else $error("Group B write did not land at cycle end.");

  AST_LATCH_HOLD: assert property (
    !grp_wr[1] |=> $stable(o_pins_b))
    else $error("Group B latch changed without a write.");

  AST_RMW_SET: assert property (
    (i_bit_set && !i_dir_load && i_file_addr == gpio_pkg::ADDR_GROUP_B)
      |=> (o_pins_b == ($past(pins_sync[1]) | (8'h01 << $past(i_bit_pos)))))
    else $error("Bit set did not rewrite latch from pins.");

  AST_DIR_UNMAPPED: assert property (
    (i_dir_load && !op_hit) |=> $stable(o_pins_a_oe) && $stable(o_pins_b_oe) && $stable(o_pins_e_oe))
    else $error("Direction changed by unmapped operand.");

  AST_DIR_HOLD: assert property (
    (!b_write_any ##1 !b_write_any) |-> $stable(o_pins_b_oe))
    else $error("Group B direction changed without a load.");

  AST_READ_A: assert property (
    (i_rd_en && i_file_addr == gpio_pkg::ADDR_GROUP_A)
      |=> o_rd_valid && (o_rd_data == ($past(pins_sync[0]) & gpio_pkg::MASK_GROUP_A)))
    else $error("Group A read did not return masked pin level.");

  AST_READ_E: assert property (
    (i_rd_en && i_file_addr == gpio_pkg::ADDR_GROUP_E && VARIANT == gpio_pkg::VARIANT_LARGE)
      |=> (o_rd_data == ($past(pins_sync[4]) & gpio_pkg::MASK_GROUP_E)))
    else $error("Group E read did not return masked pin level.");

  AST_READ_STORAGE: assert property (
    (i_rd_en && i_file_addr == gpio_pkg::ADDR_GROUP_C && VARIANT == gpio_pkg::VARIANT_SMALL)
      |=> (o_rd_data == $past(o_pins_c)))
    else $error("Group C storage read did not return the stored byte.");

  AST_READ_UNMAPPED: assert property (
    (i_rd_en && !op_hit) |=> !o_rd_valid && (o_rd_data == gpio_pkg::READ_UNMAPPED))
    else $error("Unmapped read answered.");

  AST_VALID_ONLY_READ: assert property (
    o_rd_valid |-> $past(i_rd_en))
    else $error("Read valid without a read strobe.");

  AST_A_OE_UPPER: assert property (
    o_pins_a_oe[7:4] == 4'h0)
    else $error("Group A unimplemented bits driven.");

  AST_E_OE_LOWER: assert property (
    o_pins_e_oe[3:0] == 4'h0)
    else $error("Group E unimplemented bits driven.");

  AST_C_STORAGE_OE: assert property (
    (VARIANT == gpio_pkg::VARIANT_SMALL) |-> (o_pins_c_oe == 8'h00))
    else $error("Group C driven on the smallest variant.");

  AST_DE_STORAGE_OE: assert property (
    (VARIANT != gpio_pkg::VARIANT_LARGE) |-> (o_pins_d_oe == 8'h00) && (o_pins_e_oe == 8'h00))
    else $error("Group D or E driven below the largest variant.");

  AST_DIR_LOAD_A: assert property (
    (i_dir_load && i_file_addr == gpio_pkg::ADDR_GROUP_A)
      |=> (o_pins_a_oe == (~$past(i_w_reg) & gpio_pkg::MASK_GROUP_A)))
    else $error("Group A direction load did not follow W.");

  AST_WRITE_A: assert property (
    (do_wr && op_idx == gpio_pkg::IDX_GROUP_A)
      |=> (o_pins_a == ($past(i_wr_data) & gpio_pkg::MASK_GROUP_A)))
    else $error("Group A write did not land masked.");

  AST_WRITE_E: assert property (
    (do_wr && op_idx == gpio_pkg::IDX_GROUP_E && VARIANT == gpio_pkg::VARIANT_LARGE)
      |=> (o_pins_e == ($past(i_wr_data) & gpio_pkg::MASK_GROUP_E)))
    else $error("Group E write did not land masked.");

  AST_RMW_CLR: assert property (
    (i_bit_clr && !i_bit_set && !i_dir_load && i_file_addr == gpio_pkg::ADDR_GROUP_B)
      |=> (o_pins_b == ($past(pins_sync[1]) & ~(8'h01 << $past(i_bit_pos)))))
    else $error("Bit clear did not rewrite latch from pins.");

  AST_DIR_KEEPS_LATCH: assert property (
    (i_dir_load && i_file_addr == gpio_pkg::ADDR_GROUP_B) |=> $stable(o_pins_b))
    else $error("Direction load disturbed the group B latch.");

  COV_WRITE_THEN_READ: cover property (
    (do_wr && op_idx == gpio_pkg::IDX_GROUP_B) ##1 (i_rd_en && i_file_addr == gpio_pkg::ADDR_GROUP_B));

  COV_BIT_CLEAR: cover property (
    i_bit_clr && !i_bit_set && i_file_addr == gpio_pkg::ADDR_GROUP_B);

  COV_DIR_THEN_WRITE: cover property (
    grp_dir[0] ##1 grp_wr[0]);

  COV_BIT_SET: cover property (
    i_bit_set && i_file_addr == gpio_pkg::ADDR_GROUP_B);

  COV_UNMAPPED_OP: cover property (
    i_dir_load && !op_hit);

endmodule

// ==== testbench/pin_board.sv ====
// ============================================================================
// Board side of one eight-pin group.
module pin_board (
  input  wire logic [7:0] i_latch,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_level
);
  timeunit 1ns;
  timeprecision 1ns;

  // Every pin has a pull-up, so a pin nobody drives settles high and never reads as a lucky zero.
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (i_oe[b]) o_level[b] = i_latch[b];
      else if (i_ext_en[b]) o_level[b] = i_ext[b];
      else o_level[b] = 1'b1;
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
// ============================================================================
// Bench for the port block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [4:0] K_RD  = 5'h10;
  localparam logic [4:0] K_WR  = 5'h08;
  localparam logic [4:0] K_SET = 5'h04;
  localparam logic [4:0] K_CLR = 5'h02;
  localparam logic [4:0] K_DIR = 5'h01;

  logic       clk, rst, rd_en, wr_en, bit_set, bit_clr, dir_load, rd_valid;
  logic [4:0] addr;
  logic [7:0] wr_data, w_reg, rd_data, rd_s, oes_c, v;
  logic [2:0] bit_pos;
  logic [7:0] pin [5];
  logic [7:0] lat [5];
  logic [7:0] oe [5];
  logic [7:0] ext_en [5];
  logic [7:0] e_lat [5];
  logic [7:0] e_dir [5];
  logic [7:0] ext [5]  = '{8'h55, 8'haa, 8'hc6, 8'h39, 8'h7e};
  logic [7:0] wdat [5] = '{8'h96, 8'h69, 8'ha5, 8'h3c, 8'hd2};
  logic [7:0] dirw [5] = '{8'h0f, 8'h5a, 8'hf0, 8'h33, 8'h0c};
  logic [7:0] msk [5]  = '{gpio_pkg::MASK_GROUP_A, gpio_pkg::MASK_GROUP_B, gpio_pkg::MASK_GROUP_C,
                           gpio_pkg::MASK_GROUP_D, gpio_pkg::MASK_GROUP_E};
  int         err_count, check_count;

  io_ports uut (
    .i_clk(clk), .i_sys_rst(rst), .i_file_addr(addr), .i_rd_en(rd_en), .i_wr_en(wr_en), .i_wr_data(wr_data),
    .i_bit_set(bit_set), .i_bit_clr(bit_clr), .i_bit_pos(bit_pos), .i_dir_load(dir_load), .i_w_reg(w_reg),
    .i_pins_a(pin[0]), .i_pins_b(pin[1]), .i_pins_c(pin[2]), .i_pins_d(pin[3]), .i_pins_e(pin[4]),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_pins_a(lat[0]), .o_pins_b(lat[1]), .o_pins_c(lat[2]), .o_pins_d(lat[3]), .o_pins_e(lat[4]),
    .o_pins_a_oe(oe[0]), .o_pins_b_oe(oe[1]), .o_pins_c_oe(oe[2]), .o_pins_d_oe(oe[3]), .o_pins_e_oe(oe[4])
  );

  // The smallest variant sees the same stimulus; only its storage answers are judged.
  io_ports #(.VARIANT(gpio_pkg::VARIANT_SMALL)) uut_small (
    .i_clk(clk), .i_sys_rst(rst), .i_file_addr(addr), .i_rd_en(rd_en), .i_wr_en(wr_en), .i_wr_data(wr_data),
    .i_bit_set(bit_set), .i_bit_clr(bit_clr), .i_bit_pos(bit_pos), .i_dir_load(dir_load), .i_w_reg(w_reg),
    .i_pins_a(pin[0]), .i_pins_b(pin[1]), .i_pins_c(pin[2]), .i_pins_d(pin[3]), .i_pins_e(pin[4]),
    .o_rd_data(rd_s), .o_rd_valid(),
    .o_pins_a(), .o_pins_b(), .o_pins_c(), .o_pins_d(), .o_pins_e(),
    .o_pins_a_oe(), .o_pins_b_oe(), .o_pins_c_oe(oes_c), .o_pins_d_oe(), .o_pins_e_oe()
  );

  for (genvar g = 0; g < 5; g++) begin : g_board
    pin_board board (.i_latch(lat[g]), .i_oe(oe[g]), .i_ext(ext[g]), .i_ext_en(ext_en[g]), .o_level(pin[g]));
  end

  always #25 clk = ~clk;

  // ==========================================================================
  // Tasks.
  task automatic op(input logic [4:0] a, input logic [4:0] kind, input logic [7:0] d, input logic [2:0] pos);
    @(negedge clk);
    addr = a;
    {rd_en, wr_en, bit_set, bit_clr, dir_load} = kind;
    wr_data = d;
    w_reg = d;
    bit_pos = pos;
    @(negedge clk);
    {rd_en, wr_en, bit_set, bit_clr, dir_load} = 5'h00;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Expected pin level: driven bits follow the latch, the rest the board.
  function automatic logic [7:0] exp_pin(input int g);
    logic [7:0] r;
    for (int b = 0; b < 8; b++) r[b] = (!e_dir[g][b] && msk[g][b]) ? e_lat[g][b] : (ext_en[g][b] ? ext[g][b] : 1'b1);
    return r & msk[g];
  endfunction

  function automatic logic [4:0] ga(input int g);
    return 5'(gpio_pkg::ADDR_GROUP_A + g);
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog, far beyond the fewer than a hundred cycles the sequence needs.
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    stop_test();
  end

  // ==========================================================================
  // Sequence.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 5'h00;
    {rd_en, wr_en, bit_set, bit_clr, dir_load} = 5'h00;
    wr_data = 8'h00;
    w_reg = 8'h00;
    bit_pos = 3'h0;
    for (int g = 0; g < 5; g++) begin
      ext_en[g] = 8'hff;
      e_dir[g] = 8'hff;
    end
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int g = 0; g < 5; g++) chk("oe_reset", 8'h00, oe[g]);
    for (int g = 0; g < 5; g++) begin
      op(ga(g), K_WR, wdat[g], 3'h0);
      e_lat[g] = wdat[g] & msk[g];
      chk("latch_wr", e_lat[g], lat[g]);
    end
    for (int g = 0; g < 5; g++) begin
      op(ga(g), K_DIR, dirw[g], 3'h0);
      e_dir[g] = dirw[g];
      ext_en[g] = dirw[g];
      chk("oe_load", ~dirw[g] & msk[g], oe[g]);
      chk("latch_hold", e_lat[g], lat[g]);
    end
    repeat (3) @(negedge clk);
    for (int g = 0; g < 5; g++) begin
      op(ga(g), K_RD, 8'h00, 3'h0);
      chk("rd_valid", 8'h01, {7'h00, rd_valid});
      chk("rd_pins", exp_pin(g), rd_data);
      chk("drive", e_lat[g] & ~e_dir[g] & msk[g], pin[g] & ~e_dir[g] & msk[g]);
    end
    // Group B mixes inputs and outputs, so each bit op overwrites input latches.
    for (int k = 0; k < 8; k++) begin
      v = exp_pin(1);
      e_lat[1] = k[0] ? v & ~(8'h01 << k) : v | (8'h01 << k);
      op(gpio_pkg::ADDR_GROUP_B, k[0] ? K_CLR : K_SET, 8'h00, 3'(k));
      chk("latch_rmw", e_lat[1], lat[1]);
      repeat (3) @(negedge clk);
    end
    op(5'h0a, K_RD | K_WR | K_DIR, 8'h00, 3'h0);
    chk("rd_unmapped_valid", 8'h00, {7'h00, rd_valid});
    chk("rd_unmapped_data", gpio_pkg::READ_UNMAPPED, rd_data);
    for (int g = 0; g < 5; g++) begin
      chk("oe_unmapped", ~e_dir[g] & msk[g], oe[g]);
      chk("latch_unmapped", e_lat[g], lat[g]);
    end
    v = exp_pin(1);
    op(gpio_pkg::ADDR_GROUP_B, K_RD | K_WR, ~e_lat[1], 3'h0);
    chk("rd_same_cycle", v, rd_data);
    e_lat[1] = ~e_lat[1];
    chk("latch_same_cycle", e_lat[1], lat[1]);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int g = 0; g < 5; g++) begin
      chk("oe_rerst", 8'h00, oe[g]);
      chk("latch_rerst", e_lat[g], lat[g]);
    end
    for (int g = 2; g < 5; g++) begin
      op(ga(g), K_RD, 8'h00, 3'h0);
      chk("storage", wdat[g], rd_s);
    end
    chk("storage_oe", 8'h00, oes_c);
    stop_test();
  end
endmodule
